// ---- core/kpd_debounce.sv ----
// per-pin debounce counters running on the divided slow tick
`timescale 1ns/10ps
module kpd_debounce
  import kpd_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // control
  input  wire logic                    tick_i,
  input  wire logic [KPD_DC_W-1:0]     dc_i,
  input  wire logic                    hold_i,
  input  wire logic [KPD_IRQ_PINS-1:0] act_i,
  // result
  output logic                         fire_o
);
  logic [KPD_IRQ_PINS-1:0] s1_r, s1_nxt, s2_r, s2_nxt, hit;
  logic [KPD_DC_W-1:0]     cnt_r [KPD_IRQ_PINS];
  logic [KPD_DC_W-1:0]     cnt_nxt [KPD_IRQ_PINS];

  genvar i;
  generate
    for (i = 0; i < KPD_IRQ_PINS; i++) begin : g_pin
      // first stage every clock, second on the tick: sync adds at most one whole tick
      always_comb begin
        s1_nxt[i] = act_i[i];
        s2_nxt[i] = tick_i ? s1_r[i] : s2_r[i];
        hit[i] = tick_i && s2_r[i] && !hold_i && (cnt_r[i] == dc_i);
        cnt_nxt[i] = cnt_r[i];
        if (!s2_r[i] || hold_i) begin
          cnt_nxt[i] = '0;
        end else if (tick_i && !hit[i]) begin
          cnt_nxt[i] = cnt_r[i] + 3'h1;
        end
      end
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          cnt_r[i] <= '0;
        end else begin
          s1_r[i] <= s1_nxt[i];
          s2_r[i] <= s2_nxt[i];
          cnt_r[i] <= cnt_nxt[i];
        end
      end

      property p_restart;
        @(posedge clk_i) disable iff (rst_i) !s2_r[i] |=> cnt_r[i] == 3'h0;
      endproperty
      a_restart: assert property (p_restart) else $error("counter not restarted");
      property p_sync;
        @(posedge clk_i) disable iff (rst_i) tick_i |=> s2_r[i] == $past(s1_r[i]);
      endproperty
      a_sync: assert property (p_sync) else $error("sync stage skipped");
    end
  endgenerate

  assign fire_o = |hit;

  property p_fire;
    @(posedge clk_i) disable iff (rst_i) fire_o |-> tick_i && !hold_i;
  endproperty
  a_fire: assert property (p_fire) else $error("fire off tick or while held");
endmodule

// ---- core/kpd_io.sv ----
// keypad i/o block: avalon register slave, pin logic, debounce interrupt
`timescale 1ns/10ps
module kpd_io
  import kpd_pkg::*;
#(
  parameter int          PRESCALE_CYC = KPD_PRESCALE_CYC,
  parameter logic [11:0] OD_ONLY_PINS = KPD_OD_ONLY_RST
)(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // avalon-mm slave
  input  wire logic [31:0]         avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // keypad pins
  input  wire logic [KPD_PINS-1:0] pin_in_i,
  output logic      [KPD_PINS-1:0] pin_out_o,
  output logic      [KPD_PINS-1:0] pin_oe_o,
  // interrupt
  output logic                     irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  logic                    ack_r, ack_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic [KPD_PINS-1:0]     dir_r, dir_nxt;
  logic [KPD_PINS-1:0]     sense_r, sense_nxt;
  logic [KPD_PINS-1:0]     pol_r, pol_nxt;
  logic [KPD_IRQ_PINS-1:0] ie_r, ie_nxt;
  logic [KPD_DC_W-1:0]     dc_r, dc_nxt;
  logic [KPD_DIV_W-1:0]    div_r, div_nxt;
  logic [KPD_STS_W-1:0]    msk_r, msk_nxt;
  logic [KPD_STS_W-1:0]    sts_r, sts_nxt;
  logic                    req_r, req_nxt;
  logic [KPD_PINS-1:0]     data_r, data_nxt;
  logic [KPD_PINS-1:0]     prev_r;
  logic [KPD_PINS-1:0]     pout_r, pout_nxt;
  logic [KPD_PINS-1:0]     poe_r, poe_nxt;
  logic [KPD_PRE_W-1:0]    pre_r, pre_nxt;
  logic [KPD_DIV_W-1:0]    dcnt_r, dcnt_nxt;
  logic                    tick_r, tick_nxt;

  logic                    wr_go;
  logic                    rd_go;
  logic                    wr_data;
  logic                    wr_sts;
  logic [KPD_PINS-1:0]     od;
  logic [KPD_PINS-1:0]     edge_hit;
  logic [KPD_IRQ_PINS-1:0] act;
  logic                    fire;

  //////////////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, so read data is registered before use
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
  assign avs_readdata_o    = rdata_r;
  assign wr_go             = avs_write_i && ack_r;
  assign rd_go             = avs_read_i && !ack_r;
  assign wr_data           = wr_go && (avs_address_i == KPD_DATA_ADDR);
  assign wr_sts            = wr_go && (avs_address_i == KPD_STS_ADDR);

  always_comb begin
    ack_nxt   = (avs_read_i || avs_write_i) && !ack_r;
    rdata_nxt = rdata_r;
    if (rd_go) begin
      rdata_nxt = 32'h00000000;
      if (avs_address_i == KPD_DIR_ADDR) begin
        rdata_nxt[KPD_PINS-1:0] = dir_r;
      end else if (avs_address_i == KPD_DATA_ADDR) begin
        rdata_nxt[KPD_PINS-1:0] = data_r;
      end else if (avs_address_i == KPD_IE_ADDR) begin
        rdata_nxt[KPD_IRQ_PINS-1:0] = ie_r;
      end else if (avs_address_i == KPD_SENSE_ADDR) begin
        rdata_nxt[KPD_PINS-1:0] = sense_r;
      end else if (avs_address_i == KPD_POL_ADDR) begin
        rdata_nxt[KPD_PINS-1:0] = pol_r;
      end else if (avs_address_i == KPD_DIV_ADDR) begin
        rdata_nxt[KPD_DIV_W-1:0] = div_r;
      end else if (avs_address_i == KPD_CTRL_ADDR) begin
        rdata_nxt[KPD_CTRL_REQ_BIT] = req_r;
        rdata_nxt[KPD_DC_LSB +: KPD_DC_W] = dc_r;
      end else if (avs_address_i == KPD_STS_ADDR) begin
        rdata_nxt[KPD_STS_W-1:0] = sts_r;
      end else if (avs_address_i == KPD_MSK_ADDR) begin
        rdata_nxt[KPD_STS_W-1:0] = msk_r;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers; unmapped writes are dropped
  always_comb begin
    dir_nxt   = dir_r;
    sense_nxt = sense_r;
    pol_nxt   = pol_r;
    ie_nxt    = ie_r;
    dc_nxt    = dc_r;
    div_nxt   = div_r;
    msk_nxt   = msk_r;
    if (wr_go) begin
      if (avs_address_i == KPD_DIR_ADDR) begin
        dir_nxt = avs_writedata_i[KPD_PINS-1:0];
      end else if (avs_address_i == KPD_IE_ADDR) begin
        ie_nxt = avs_writedata_i[KPD_IRQ_PINS-1:0];
      end else if (avs_address_i == KPD_SENSE_ADDR) begin
        sense_nxt = avs_writedata_i[KPD_PINS-1:0];
      end else if (avs_address_i == KPD_POL_ADDR) begin
        pol_nxt = avs_writedata_i[KPD_PINS-1:0];
      end else if (avs_address_i == KPD_DIV_ADDR) begin
        div_nxt = avs_writedata_i[KPD_DIV_W-1:0];
      end else if (avs_address_i == KPD_CTRL_ADDR) begin
        dc_nxt = avs_writedata_i[KPD_DC_LSB +: KPD_DC_W];
      end else if (avs_address_i == KPD_MSK_ADDR) begin
        msk_nxt = avs_writedata_i[KPD_STS_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_r   <= KPD_PIN_RST;
      sense_r <= KPD_PIN_RST;
      pol_r   <= KPD_PIN_RST;
      ie_r    <= KPD_IE_RST;
      dc_r    <= KPD_DC_RST;
      div_r   <= KPD_DIV_RST;
      msk_r   <= KPD_STS_RST;
    end else begin
      dir_r   <= dir_nxt;
      sense_r <= sense_nxt;
      pol_r   <= pol_nxt;
      ie_r    <= ie_nxt;
      dc_r    <= dc_nxt;
      div_r   <= div_nxt;
      msk_r   <= msk_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-pin data register and drivers
  genvar i;
  generate
    for (i = 0; i < KPD_PINS; i++) begin : g_pin
      always_comb begin
        od[i] = sense_r[i] || OD_ONLY_PINS[i];
        edge_hit[i] = pol_r[i] ? (pin_in_i[i] && !prev_r[i]) : (!pin_in_i[i] && prev_r[i]);
        if (dir_r[i]) begin
          data_nxt[i] = wr_data ? avs_writedata_i[i] : data_r[i];
        end else if (!sense_r[i]) begin
          data_nxt[i] = pol_r[i] ? pin_in_i[i] : !pin_in_i[i];
        end else begin
          // a new edge beats a same-cycle clear
          data_nxt[i] = edge_hit[i] || (data_r[i] && !(wr_data && avs_writedata_i[i]));
        end
        if (!dir_r[i]) begin
          pout_nxt[i] = 1'b0;
          poe_nxt[i]  = 1'b0;
        end else if (!od[i]) begin
          pout_nxt[i] = pol_r[i] ? data_r[i] : !data_r[i];
          poe_nxt[i]  = 1'b1;
        end else begin
          pout_nxt[i] = 1'b0;
          poe_nxt[i]  = pol_r[i] ? !data_r[i] : data_r[i];
        end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          data_r[i] <= 1'b0;
          prev_r[i] <= 1'b0;
          pout_r[i] <= 1'b0;
          poe_r[i]  <= 1'b0;
        end else begin
          data_r[i] <= data_nxt[i];
          prev_r[i] <= pin_in_i[i];
          pout_r[i] <= pout_nxt[i];
          poe_r[i]  <= poe_nxt[i];
        end
      end

      property p_in_off;
        @(posedge clk_i) disable iff (rst_i) !dir_r[i] |=> !pin_oe_o[i];
      endproperty
      a_in_off: assert property (p_in_off) else $error("input pin driven");
      property p_drive;
        @(posedge clk_i) disable iff (rst_i) dir_r[i] && !od[i] |=>
          pin_oe_o[i] && (pin_out_o[i] == ($past(pol_r[i]) ? $past(data_r[i]) : !$past(data_r[i])));
      endproperty
      a_drive: assert property (p_drive) else $error("direct drive wrong");
      property p_od_hi;
        @(posedge clk_i) disable iff (rst_i) dir_r[i] && od[i] && pol_r[i] |=>
          !pin_out_o[i] && (pin_oe_o[i] == !$past(data_r[i]));
      endproperty
      a_od_hi: assert property (p_od_hi) else $error("open drain pol 1 wrong");
      property p_od_lo;
        @(posedge clk_i) disable iff (rst_i) dir_r[i] && od[i] && !pol_r[i] |=>
          !pin_out_o[i] && (pin_oe_o[i] == $past(data_r[i]));
      endproperty
      a_od_lo: assert property (p_od_lo) else $error("open drain pol 0 wrong");
      property p_od_only;
        @(posedge clk_i) disable iff (rst_i) dir_r[i] && OD_ONLY_PINS[i] |=> !pin_out_o[i];
      endproperty
      a_od_only: assert property (p_od_only) else $error("open-drain-only pin pushed high");
      property p_level;
        @(posedge clk_i) disable iff (rst_i) !dir_r[i] && !sense_r[i] |=>
          data_r[i] == ($past(pol_r[i]) ? $past(pin_in_i[i]) : !$past(pin_in_i[i]));
      endproperty
      a_level: assert property (p_level) else $error("level input wrong");
      property p_edge;
        @(posedge clk_i) disable iff (rst_i) $past(!dir_r[i] && sense_r[i] && pol_r[i])
          && $rose(prev_r[i]) |-> data_r[i];
      endproperty
      a_edge: assert property (p_edge) else $error("rising edge not caught");
      property p_hold;
        @(posedge clk_i) disable iff (rst_i) !dir_r[i] && sense_r[i] && data_r[i]
          && !(wr_data && avs_writedata_i[i]) |=> data_r[i];
      endproperty
      a_hold: assert property (p_hold) else $error("transition bit lost");
    end
  endgenerate

  assign pin_out_o = pout_r;
  assign pin_oe_o  = poe_r;

  //////////////////////////////////////////////////////////////////////////////
  // slow tick: prescale to 32 kHz, then divide by the divisor register plus one
  always_comb begin
    tick_nxt = 1'b0;
    dcnt_nxt = dcnt_r;
    if (pre_r == KPD_PRE_W'(PRESCALE_CYC - 1)) begin
      pre_nxt = '0;
      if (dcnt_r >= div_r) begin
        dcnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        dcnt_nxt = dcnt_r + 8'h01;
      end
    end else begin
      pre_nxt = pre_r + 14'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_r  <= '0;
      dcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_nxt;
      dcnt_r <= dcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt detection; software keeps these pins level-sensitive
  assign act = ie_r & ~dir_r[KPD_IRQ_PINS-1:0] & ~(pin_in_i[KPD_IRQ_PINS-1:0]
               ^ pol_r[KPD_IRQ_PINS-1:0]);

  kpd_debounce u_deb (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (tick_r),
    .dc_i   (dc_r),
    .hold_i (req_r),
    .act_i  (act),
    .fire_o (fire)
  );

  // status write-one-to-clear; events win over a same-cycle clear
  always_comb begin
    sts_nxt = sts_r;
    if (wr_sts) begin
      sts_nxt = sts_r & ~avs_writedata_i[KPD_STS_W-1:0];
    end
    sts_nxt[KPD_STS_KEY]  = sts_nxt[KPD_STS_KEY] || fire;
    sts_nxt[KPD_STS_EDGE] = sts_nxt[KPD_STS_EDGE] || (|(edge_hit & sense_r & ~dir_r));
    req_nxt = fire || (req_r && !(wr_sts && avs_writedata_i[KPD_STS_KEY]));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sts_r <= KPD_STS_RST;
      req_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      req_r <= req_nxt;
    end
  end

  assign irq_o = |(sts_r & msk_r);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_req_set;
    @(posedge clk_i) disable iff (rst_i) fire |=> req_r && sts_r[KPD_STS_KEY];
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not raised");
  property p_req_keep;
    @(posedge clk_i) disable iff (rst_i) req_r && !wr_sts |=> req_r;
  endproperty
  a_req_keep: assert property (p_req_keep) else $error("request dropped");
  property p_no_refire;
    @(posedge clk_i) disable iff (rst_i) req_r |-> !fire;
  endproperty
  a_no_refire: assert property (p_no_refire) else $error("fired while pending");
  property p_ctrl_rd;
    @(posedge clk_i) disable iff (rst_i) rd_go && avs_address_i == KPD_CTRL_ADDR |=>
      avs_readdata_o[KPD_CTRL_REQ_BIT] == $past(req_r);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control flag wrong");
  property p_bus;
    @(posedge clk_i) disable iff (rst_i) avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  property p_tick;
    @(posedge clk_i) disable iff (rst_i) tick_r |=> !tick_r;
  endproperty
  a_tick: assert property (p_tick) else $error("tick wider than one cycle");

  c_fire: cover property (@(posedge clk_i) disable iff (rst_i) fire);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_clr: cover property (@(posedge clk_i) disable iff (rst_i) req_r ##1 !req_r);
  c_edge: cover property (@(posedge clk_i) disable iff (rst_i) $rose(sts_r[KPD_STS_EDGE]));
endmodule

// ---- core/kpd_pkg.sv ----
// constants, register map and field layout of the keypad i/o block
// Contract
// - sense 0 level/direct, 1 transition/open-drain
// - open-drain-only pins always open-drain as output
// - level input: polarity 1 plain, 0 inverted
// - polarity sets active level for interrupt
// - transition input: polarity picks edge, sets bit
// - direct output: polarity 1 plain, 0 inverted
// - open-drain pol 1: low when data 0
// - open-drain pol 0: low when data 1
// - control bit 3 shows pending keypad request
// - delay code n: fire after n+1..n+2 ticks
// - debounce ticks from divided 32 kHz clock
// - direction 1 output, 0 input
// - leaving active level restarts counter, no interrupt
// - pending request blocks further interrupt detection
// - only enabled input pins 7..0 interrupt; code also interrupts via status bit 1 on any transition input 11..0 edge
package kpd_pkg;
  localparam int          KPD_PINS        = 12;
  localparam int          KPD_IRQ_PINS    = 8;
  // bus byte addresses
  localparam logic [31:0] KPD_DIR_ADDR    = 32'h700C7000;
  localparam logic [31:0] KPD_DATA_ADDR   = 32'h700C7004;
  localparam logic [31:0] KPD_IE_ADDR     = 32'h700C7008;
  localparam logic [31:0] KPD_SENSE_ADDR  = 32'h700C700C;
  localparam logic [31:0] KPD_POL_ADDR    = 32'h700C7010;
  localparam logic [31:0] KPD_DIV_ADDR    = 32'h700C7014;
  localparam logic [31:0] KPD_CTRL_ADDR   = 32'h700C7018;
  localparam logic [31:0] KPD_STS_ADDR    = 32'h700C7024;
  localparam logic [31:0] KPD_MSK_ADDR    = 32'h700C7028;
  // control register fields
  localparam int          KPD_CTRL_REQ_BIT = 3;
  localparam int          KPD_DC_LSB      = 0;
  localparam int          KPD_DC_W        = 3;
  localparam int          KPD_DIV_W       = 8;
  // status and mask fields
  localparam int          KPD_STS_W       = 2;
  localparam int          KPD_STS_KEY     = 0;
  localparam int          KPD_STS_EDGE    = 1;
  // reset values
  localparam logic [11:0] KPD_PIN_RST     = 12'h000;
  localparam logic [7:0]  KPD_IE_RST      = 8'h00;
  localparam logic [2:0]  KPD_DC_RST      = 3'h0;
  localparam logic [7:0]  KPD_DIV_RST     = 8'h00;
  localparam logic [1:0]  KPD_STS_RST     = 2'h0;
  localparam logic [11:0] KPD_OD_ONLY_RST = 12'h000;
  // timing
  localparam int          KPD_CLK_HZ      = 250000000;
  localparam int          KPD_SLOW_HZ     = 32768;
  localparam int          KPD_PRESCALE_CYC = KPD_CLK_HZ / KPD_SLOW_HZ;
  localparam int          KPD_PRE_W       = 14;
endpackage

// ---- testbench/kpd_matrix.sv ----
// keypad switch matrix model with pull-ups on every pin
`timescale 1ns/10ps
module kpd_matrix
  import kpd_pkg::*;
(
  // pins from the block
  input  wire logic [KPD_PINS-1:0] out_i,
  input  wire logic [KPD_PINS-1:0] oe_i,
  // keys at row*6+col, rows 5..0, cols 11..6; gnd shorts a pin low
  input  wire logic [35:0]         key_i,
  input  wire logic [KPD_PINS-1:0] gnd_i,
  // resolved pin levels
  output logic      [KPD_PINS-1:0] lvl_o
);
  logic [KPD_PINS-1:0] base;
  // undriven pins go to the pull-up level, never to a held value
  always_comb begin
    base  = ~(oe_i & ~out_i) & ~gnd_i;
    lvl_o = base;
    for (int r = 0; r < 6; r++) begin
      for (int c = 0; c < 6; c++) begin
        if (key_i[r*6+c]) begin
          lvl_o[r] = lvl_o[r] & base[c+6];
        end
      end
    end
  end
endmodule

// ---- testbench/test_keypad_io_debounce_irq.sv ----
// self-checking bench for the keypad i/o block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_keypad_io_debounce_irq
  import kpd_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [31:0] addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wait_req;
  logic [11:0] pout;
  logic [11:0] poe;
  logic [11:0] lvl;
  logic [11:0] gnd;
  logic [35:0] key;
  logic        irq;
  logic [31:0] q;
  logic [11:0] sen;
  logic        od;
  logic        lv;
  int          failures;
  int          compares;
  logic [31:0] regs [9] = '{KPD_DIR_ADDR, KPD_DATA_ADDR, KPD_IE_ADDR, KPD_SENSE_ADDR,
                            KPD_POL_ADDR, KPD_DIV_ADDR, KPD_CTRL_ADDR, KPD_STS_ADDR, KPD_MSK_ADDR};
  logic [7:0]  pats [3] = '{8'h00, 8'hA5, 8'h3C};
  localparam logic [11:0] POLV = 12'h500;

  // short prescale keeps debounce ticks a few clocks apart
  kpd_io #(.PRESCALE_CYC(4), .OD_ONLY_PINS(12'h800)) u_dut (
    .clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe), .irq_o(irq));
  kpd_matrix u_keys (.out_i(pout), .oe_i(poe), .key_i(key), .gnd_i(gnd), .lvl_o(lvl));

  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    `CHK("wait_cycles", 2, n)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    `CHK("readback", d & m, q)
  endtask

  task automatic data_is(input logic [7:0] e);
    bus(1'b0, KPD_DATA_ADDR, 32'h0);
    `CHK("data", e, q[7:0])
  endtask

  task automatic irq_is(input logic e);
    @(posedge clk);
    `CHK("irq", e, irq)
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask

  task final_report;
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    `CHK("watchdog", 1'b0, 1'b1)
    final_report();
  end

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    gnd = 12'h000;
    key = 36'h0;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // all registers clear, unmapped place reads zero
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0);
      `CHK("reset", 32'h0, q)
    end
    wrc(32'h700C7030, 32'hFFF, 32'h0);
    // outputs on pins 11..8, pin 11 open-drain only
    wrc(KPD_DIR_ADDR, 32'hFFFFFF00, 32'hFFF);
    wrc(KPD_POL_ADDR, {20'h0, POLV}, 32'hFFF);
    for (int s = 0; s < 2; s++) begin
      sen = (s == 0) ? 12'hC00 : 12'h400;
      wrc(KPD_SENSE_ADDR, {20'h0, sen}, 32'hFFF);
      for (int d = 0; d < 16; d++) begin
        bus(1'b1, KPD_DATA_ADDR, {20'h0, d[3:0], 8'h00});
        repeat (2) @(posedge clk);
        for (int p = 8; p < 12; p++) begin
          od = sen[p] | (p == 11);
          lv = POLV[p] ? d[p-8] : ~d[p-8];
          `CHK("pin_level", lv, lvl[p])
          `CHK("pin_enable", od ? ~lv : 1'b1, poe[p])
        end
      end
    end
    // level inputs, writes have no effect on them
    wrc(KPD_SENSE_ADDR, 32'h0, 32'hFFF);
    wrc(KPD_POL_ADDR, 32'h00F, 32'hFFF);
    foreach (pats[i]) begin
      gnd <= {4'h0, pats[i]};
      repeat (3) @(posedge clk);
      bus(1'b1, KPD_DATA_ADDR, 32'hFF);
      data_is({pats[i][7:4], ~pats[i][3:0]});
    end
    // transition inputs: 3..0 rising, 7..4 falling, sticky until write one
    gnd <= 12'h000;
    wrc(KPD_SENSE_ADDR, 32'h0FF, 32'hFFF);
    bus(1'b1, KPD_DATA_ADDR, 32'hFF);
    data_is(8'h00);
    gnd <= 12'h0FF;
    repeat (4) @(posedge clk);
    data_is(8'hF0);
    gnd <= 12'h000;
    repeat (4) @(posedge clk);
    data_is(8'hFF);
    data_is(8'hFF);
    bus(1'b1, KPD_DATA_ADDR, 32'h0F);
    data_is(8'hF0);
    bus(1'b1, KPD_DATA_ADDR, 32'hF0);
    data_is(8'h00);
    // matrix: columns open-drain low, rows level inputs before enabling
    wrc(KPD_SENSE_ADDR, 32'hFC0, 32'hFFF);
    wrc(KPD_DIR_ADDR, 32'hFC0, 32'hFFF);
    wrc(KPD_POL_ADDR, 32'h0, 32'hFFF);
    bus(1'b1, KPD_DATA_ADDR, 32'hFC0);
    wrc(KPD_DIV_ADDR, 32'h1, 32'hFF);
    wrc(KPD_CTRL_ADDR, 32'hF9, 32'h7);
    bus(1'b1, KPD_STS_ADDR, 32'h3);
    wrc(KPD_MSK_ADDR, 32'h1, 32'h3);
    wrc(KPD_IE_ADDR, 32'hF01, 32'hFF);
    // with delay code 1, a bounce shorter than one tick never fires
    key <= 36'h1;
    repeat (3) @(posedge clk);
    key <= 36'h0;
    repeat (80) @(posedge clk);
    irq_is(1'b0);
    key <= 36'h40;
    repeat (80) @(posedge clk);
    irq_is(1'b0);
    key <= 36'h1;
    repeat (12) @(posedge clk);
    irq_is(1'b0);
    wait_irq();
    irq_is(1'b1);
    bus(1'b0, KPD_CTRL_ADDR, 32'h0);
    `CHK("ctrl", 32'h9, q)
    bus(1'b1, KPD_MSK_ADDR, 32'h0);
    irq_is(1'b0);
    bus(1'b0, KPD_STS_ADDR, 32'h0);
    `CHK("status", 32'h1, q)
    bus(1'b1, KPD_MSK_ADDR, 32'h1);
    irq_is(1'b1);
    // release becomes the active level, clear then wait again
    key <= 36'h0;
    bus(1'b1, KPD_POL_ADDR, 32'h1);
    bus(1'b1, KPD_STS_ADDR, 32'h1);
    irq_is(1'b0);
    bus(1'b0, KPD_CTRL_ADDR, 32'h0);
    `CHK("ctrl", 32'h1, q)
    wait_irq();
    irq_is(1'b1);
    bus(1'b1, KPD_STS_ADDR, 32'h1);
    final_report();
  end
endmodule
